// *** rtl/flp_defines.vh ***
// Purpose: constants for the flash lock-bit host controller
// Assumes: apb slave registers of our own, word aligned
// Notes: flash command codes for lock-bit setup/confirm are module parameters
`ifndef FLP_DEFINES_VH
`define FLP_DEFINES_VH
`define FLP_REG_CTRL      12'h000
`define FLP_REG_ADDR      12'h004
`define FLP_REG_STATUS    12'h008
`define FLP_REG_FSTS      12'h00C
`define FLP_CTRL_GO       0
`define FLP_CTRL_OP_LSB   1
`define FLP_CTRL_OP_MSB   2
`define FLP_CTRL_RSTPD    3
`define FLP_OP_SET_BLOCK  2'h0
`define FLP_OP_SET_PERM   2'h1
`define FLP_OP_CLEAR      2'h2
`define FLP_OP_CLR_STS    2'h3
`define FLP_SR_READY      7
`define FLP_SR_ERASE_ERR  5
`define FLP_SR_PROG_ERR   4
`define FLP_SR_SUPPLY_ERR 3
`define FLP_SR_PROT_ERR   1
`define FLP_STRETCH_NS    70
`define FLP_CLK_NS        10
`define FLP_STRETCH_CYC   ((`FLP_STRETCH_NS + `FLP_CLK_NS - 1) / `FLP_CLK_NS)
`endif

// *** rtl/flp_host.v ***
// Purpose: apb-driven host that issues lock-bit command sequences to the flash
// Assumes: flash bus strobes sampled on the pclk domain; data bus two-way
// Notes: polls status through ready/busy and the read-status command
`timescale 1ns/1ps
`include "flp_defines.vh"
module flp_host #(
  parameter        AW          = 20,
  parameter [7:0]  OP_SET_SU   = 8'h60,
  parameter [7:0]  OP_SET_BLK  = 8'h01,
  parameter [7:0]  OP_SET_PERM = 8'hF1,
  parameter [7:0]  OP_CLR_CNF  = 8'hD0,
  parameter [7:0]  OP_RD_STS   = 8'h70,
  parameter [7:0]  OP_CLR_STS  = 8'h50
) (
  // clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // apb slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  // flash bus
  output reg  [AW-1:0] flash_addr,
  output reg  [7:0]    flash_dq_out,
  output reg           flash_dq_oe,
  input  wire [7:0]    flash_dq_in,
  output reg           flash_we_n,
  output reg           flash_oe_n,
  output reg           reset_powerdown_n,
  input  wire          ready_busy_n,
  // controller busy
  output reg           busy
);
  localparam ST_IDLE = 3'h0;
  localparam ST_WR   = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_RSU  = 3'h3;
  localparam ST_RD   = 3'h4;
  localparam integer STRETCH_I = `FLP_STRETCH_CYC;
  localparam [7:0]   STRETCH   = STRETCH_I[7:0];

  reg  [2:0]    state;
  reg  [7:0]    cnt;
  reg  [1:0]    op;
  reg           phase;
  reg  [AW-1:0] target;
  reg  [7:0]    flash_status;
  reg           rb_s1;
  reg           rb_s2;
  reg           rb_s3;
  reg           rb_ready;
  reg  [7:0]    dq_s1;
  reg  [7:0]    dq_s2;
  reg  [7:0]    dq_s3;
  reg  [7:0]    next_cmd;

  // register decode shared by the write paths
  function reg_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      reg_hit = (addr == offset);
    end
  endfunction

  wire acc = psel & penable & ~pready;
  wire wr  = acc & pwrite;
  wire go  = wr && reg_hit(paddr, `FLP_REG_CTRL) && pwdata[`FLP_CTRL_GO] && state == ST_IDLE;

  // command byte for the current phase: setup first, then confirm of the chosen lock operation; clear-status is one byte
  always @* begin
    case (op)
      `FLP_OP_SET_BLOCK: next_cmd = phase ? OP_SET_BLK : OP_SET_SU;
      `FLP_OP_SET_PERM:  next_cmd = phase ? OP_SET_PERM : OP_SET_SU;
      `FLP_OP_CLEAR:     next_cmd = phase ? OP_CLR_CNF : OP_SET_SU;
      default:           next_cmd = OP_CLR_STS;
    endcase
  end

  // three-stage synchronisers for the flash pins; a ready/busy change counts once stages 2 and 3 agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_s1    <= 1'b0;
      rb_s2    <= 1'b0;
      rb_s3    <= 1'b0;
      rb_ready <= 1'b0;
      dq_s1    <= 8'h00;
      dq_s2    <= 8'h00;
      dq_s3    <= 8'h00;
    end else begin
      rb_s1 <= ready_busy_n;
      rb_s2 <= rb_s1;
      rb_s3 <= rb_s2;
      if (rb_s2 == rb_s3)
        rb_ready <= rb_s3;
      dq_s1 <= flash_dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  // apb side
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata            <= 32'h0;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
      target            <= {AW{1'b0}};
      reset_powerdown_n <= 1'b0;
    end else begin
      pready  <= acc;
      pslverr <= acc && paddr > `FLP_REG_FSTS;
      // address writes and the go bit are ignored while a sequence runs
      if (wr && reg_hit(paddr, `FLP_REG_ADDR) && state == ST_IDLE)
        target <= pwdata[AW-1:0];
      if (wr && reg_hit(paddr, `FLP_REG_CTRL))
        reset_powerdown_n <= pwdata[`FLP_CTRL_RSTPD];
      if (acc && !pwrite) begin
        case (paddr)
          `FLP_REG_CTRL:   prdata <= {28'h0, reset_powerdown_n, op, busy};
          `FLP_REG_ADDR:   prdata <= {{(32-AW){1'b0}}, target};
          `FLP_REG_STATUS: prdata <= {30'h0, rb_ready, busy};
          `FLP_REG_FSTS:   prdata <= {24'h0, flash_status};
          default:         prdata <= 32'h0;
        endcase
      end
    end
  end

  // flash sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= ST_IDLE;
      cnt          <= 8'h0;
      op           <= 2'h0;
      phase        <= 1'b0;
      busy         <= 1'b0;
      flash_addr   <= {AW{1'b0}};
      flash_dq_out <= 8'h0;
      flash_dq_oe  <= 1'b0;
      flash_we_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
      flash_status <= 8'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (go) begin
            op           <= pwdata[`FLP_CTRL_OP_MSB:`FLP_CTRL_OP_LSB];
            phase        <= 1'b0;
            busy         <= 1'b1;
            state        <= ST_WR;
            cnt          <= STRETCH;
            flash_addr   <= target;
            flash_dq_oe  <= 1'b1;
            flash_we_n   <= 1'b0;
          end
        end
        ST_WR: begin
          flash_dq_out <= next_cmd;
          if (cnt != 8'h0) begin
            cnt <= cnt - 8'h1;
          end else if (flash_we_n) begin
            // strobe stayed high one cycle so the flash latches setup; start confirm
            flash_we_n  <= 1'b0;
            flash_dq_oe <= 1'b1;
            cnt         <= STRETCH;
          end else begin
            flash_we_n  <= 1'b1;
            flash_dq_oe <= 1'b0;
            if (!phase && op != `FLP_OP_CLR_STS) begin
              phase <= 1'b1;
            end else begin
              state <= ST_WAIT;
              cnt   <= STRETCH;
            end
          end
        end
        ST_WAIT: begin
          // gap lets the flash drive busy before polling
          if (cnt != 8'h0)
            cnt <= cnt - 8'h1;
          else if (rb_ready) begin
            state        <= ST_RSU;
            cnt          <= STRETCH;
            flash_dq_out <= OP_RD_STS;
            flash_dq_oe  <= 1'b1;
            flash_we_n   <= 1'b0;
          end
        end
        ST_RSU: begin
          if (cnt != 8'h0)
            cnt <= cnt - 8'h1;
          else if (!flash_we_n) begin
            flash_we_n  <= 1'b1;
            flash_dq_oe <= 1'b0;
            cnt         <= STRETCH;
          end else begin
            flash_oe_n <= 1'b0;
            cnt        <= STRETCH;
            state      <= ST_RD;
          end
        end
        ST_RD: begin
          if (cnt != 8'h0)
            cnt <= cnt - 8'h1;
          else begin
            // stage 3 has held the status byte for several cycles by now
            flash_status <= dq_s3;
            flash_oe_n   <= 1'b1;
            busy         <= 1'b0;
            state        <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // flp_host

// *** verif/flp_flash_model.sv ***
// Purpose: behavioural lock-bit flash device
// Assumes: commands latched at we_n rising
// Notes: four blocks picked by addr[19:18]
`timescale 1ns/1ps
module flp_flash_model (
  // flash pins
  input  wire [19:0] flash_addr,
  input  wire [7:0]  flash_dq_out,
  input  wire        flash_dq_oe,
  output wire [7:0]  flash_dq_in,
  input  wire        flash_we_n,
  input  wire        flash_oe_n,
  input  wire        reset_powerdown_n,
  output reg         ready_busy_n,
  // supply lockout
  input  wire        supply_low
);
  reg [7:0] sr = 8'h80;
  reg [3:0] blk = 4'h0;
  reg       perm = 1'b0;
  reg       setup = 1'b0;
  event     run;
  // released bus shows inverted status
  assign flash_dq_in = flash_dq_oe ? flash_dq_out :
    !flash_oe_n ? {ready_busy_n, sr[6:0]} : ~sr;
  initial ready_busy_n = 1'b1;
  always @(run) begin
    ready_busy_n = 1'b0;
    #200 ready_busy_n = 1'b1;
  end
  always @(posedge flash_we_n) if (reset_powerdown_n) begin
    if (setup) begin
      setup = 1'b0;
      -> run;
      if (flash_dq_out == 8'h01) begin
        if (supply_low) sr = sr | 8'h18;
        else if (perm) sr = sr | 8'h12;
        else blk[flash_addr[19:18]] = 1'b1;
      end else if (flash_dq_out == 8'hF1) begin
        if (supply_low) sr = sr | 8'h18;
        else perm = 1'b1;
      end else if (flash_dq_out == 8'hD0) begin
        if (supply_low) sr = sr | 8'h28;
        else if (perm) sr = sr | 8'h22;
        else blk = 4'h0;
      end else sr = sr | 8'h30;
    end else if (flash_dq_out == 8'h60) setup = 1'b1;
    else if (flash_dq_out == 8'h50) sr = 8'h80;
  end
endmodule // flp_flash_model

// *** verif/flp_host_properties.sv ***
// Purpose: port checks for flp_host
// Assumes: one clock, async low reset
// Notes: strobe widths follow the sequencer counts
`timescale 1ns/1ps
module flp_host_props (
  // apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire        pready,
  input wire        pslverr,
  // flash
  input wire        flash_we_n,
  input wire        flash_oe_n,
  input wire        flash_dq_oe,
  input wire        reset_powerdown_n,
  input wire        busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ans; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_ans: assert property (p_ans) else $error("late answer");
  property p_err; psel && penable && pready |-> pslverr == (paddr > 12'h00C); endproperty
  a_err: assert property (p_err) else $error("bad slverr");
  property p_we; $fell(flash_we_n) |-> !flash_we_n [*8] ##1 flash_we_n; endproperty
  a_we: assert property (p_we) else $error("we width");
  property p_wdrv; !flash_we_n |-> busy && flash_dq_oe; endproperty
  a_wdrv: assert property (p_wdrv) else $error("we undriven");
  property p_oe; $fell(flash_oe_n) |-> !flash_oe_n [*8] ##1 flash_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("oe width");
  property p_dq; !flash_oe_n |-> !flash_dq_oe && flash_we_n; endproperty
  a_dq: assert property (p_dq) else $error("dq clash");
  property p_rp;
    $changed(reset_powerdown_n) |->
      $past(psel) && $past(penable) && $past(pwrite) && $past(paddr) == 12'h000;
  endproperty
  a_rp: assert property (p_rp) else $error("rp moved");
  property p_idle; !busy |-> flash_we_n && flash_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("idle strobe");
endmodule // flp_host_props
bind flp_host flp_host_props i_flp_host_props (.*);

// *** verif/testbench.sv ***
// Purpose: self-checking bench for flp_host
// Assumes: flash model answers every sequence issued with reset_powerdown_n high
// Notes: status bytes are sticky until cleared
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks = n_checks + 1; if ((g) !== (e)) begin \
  errors = errors + 1; $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg         supply_low = 1'b0;
  reg  [31:0] rdat;
  reg         rerr;
  integer     errors = 0;
  integer     n_checks = 0;
  wire [31:0] prdata;
  wire        pready, pslverr, flash_we_n, flash_oe_n, flash_dq_oe, busy;
  wire        reset_powerdown_n, ready_busy_n;
  wire [19:0] flash_addr;
  wire [7:0]  flash_dq_out, flash_dq_in;
  flp_host i_flp_host (.*);
  flp_flash_model i_flp_flash_model (.*);
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task run(input [1:0] op);
    begin
      apb(1'b1, 12'h000, {28'h0, 1'b1, op, 1'b1});
      do apb(1'b0, 12'h008, 32'h0); while (rdat[0] !== 1'b0);
      apb(1'b0, 12'h00C, 32'h0);
    end
  endtask
  task t_set_block;
    begin
      apb(1'b1, 12'h004, 32'h40000);
      run(2'h0);
      `CHK("fsts", 8'h80, rdat[7:0])
      `CHK("blk", 4'h2, i_flp_flash_model.blk)
      apb(1'b0, 12'h004, 32'h0);
      `CHK("addr", 32'h00040000, rdat)
      apb(1'b0, 12'h000, 32'h0);
      `CHK("ctrl", 32'h00000008, rdat)
      $display("set block done");
    end
  endtask
  task t_clear;
    begin
      supply_low <= 1'b1;
      run(2'h2);
      `CHK("fsts", 8'hA8, rdat[7:0])
      `CHK("blk", 4'h2, i_flp_flash_model.blk)
      supply_low <= 1'b0;
      run(2'h3);
      `CHK("fsts", 8'h80, rdat[7:0])
      run(2'h2);
      `CHK("blk", 4'h0, i_flp_flash_model.blk)
      apb(1'b1, 12'h000, 32'h00000001);
      do apb(1'b0, 12'h008, 32'h0); while (rdat[0] !== 1'b0);
      `CHK("blk", 4'h0, i_flp_flash_model.blk)
      $display("clear done");
    end
  endtask
  task t_perm;
    begin
      run(2'h1);
      `CHK("fsts", 8'h80, rdat[7:0])
      apb(1'b1, 12'h004, 32'hC0000);
      run(2'h0);
      `CHK("fsts", 8'h92, rdat[7:0])
      run(2'h2);
      `CHK("fsts", 8'hB2, rdat[7:0])
      `CHK("blk", 4'h0, i_flp_flash_model.blk)
      `CHK("perm", 1'b1, i_flp_flash_model.perm)
      apb(1'b0, 12'h010, 32'h0);
      `CHK("slverr", 1'b1, rerr)
      $display("permanent done");
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_set_block;
    t_clear;
    t_perm;
    end_sim;
  end
  initial begin
    #100000;
    errors = errors + 1;
    end_sim;
  end
endmodule // testbench
